// file: options_pkg.sv
// Purpose: constants for the system options and part id register bank,
//          plus the small routing stage that applies the option bits.
// Assumes: one 20 MHz system clock, synchronous active-low reset.
// Notes:   register offsets are byte addresses on a 32-bit AXI4-Lite bus.
//
// Summary of operation
// - bit 7 picks watchdog clock: kHz or bus
// - write-once fields honour only first low-byte write
// - bit 1 moves two-wire pins A/B
// - bit 0 links comparator one to timer one
// - bit 2 links comparator two to timer two
// - id high bits 7-4 reserved, writes ignored
// - id high and low registers are read-only
// - hard-coded part number spans both id registers
// - timeout-length bit picks short or long period
`timescale 1ns/1ns
package options_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OPTIONS_TWO = 8'h00;
  localparam logic [7:0] OFF_PART_ID_HIGH = 8'h04;
  localparam logic [7:0] OFF_PART_ID_LOW = 8'h08;
  localparam logic [7:0] OFF_OPTIONS_ONE = 8'h0C;
  // options two field positions
  localparam int BIT_WDOG_CLK_SEL = 7;
  localparam int BIT_SERIAL_LOC = 3;
  localparam int BIT_CMP_TWO_LINK = 2;
  localparam int BIT_TWO_WIRE_LOC = 1;
  localparam int BIT_CMP_ONE_LINK = 0;
  // options one field position
  localparam int BIT_WDOG_TIMEOUT = 6;
  // reset values
  localparam logic RST_WDOG_CLK_SEL = 1'b0;
  localparam logic RST_SERIAL_LOC = 1'b0;
  localparam logic RST_CMP_TWO_LINK = 1'b0;
  localparam logic RST_TWO_WIRE_LOC = 1'b0;
  localparam logic RST_CMP_ONE_LINK = 1'b0;
  localparam logic RST_WDOG_TIMEOUT = 1'b1;
  // part number, value arbitrary
  localparam logic [11:0] PART_NUMBER = 12'h5A3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // decoded register selection
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_OPT_TWO = 3'h1,
    SEL_ID_HIGH = 3'h3,
    SEL_ID_LOW = 3'h2,
    SEL_OPT_ONE = 3'h6
  } reg_sel_t;
endpackage

// Purpose: apply option bits to watchdog clock and timer capture inputs.
// Assumes: khz tick is a one-cycle enable from same-clock logic.
// Notes:   purely combinational; selects settle with the register bits.
module option_routing
  import options_pkg::*;
(
  // option bits
  input wire logic clk_sel_i,
  input wire logic cmp_one_link_i,
  input wire logic cmp_two_link_i,
  // sources
  input wire logic khz_tick_i,
  input wire logic cmp_one_out_i,
  input wire logic cmp_two_out_i,
  // routed results
  output logic wdog_tick_o,
  output logic timer_one_ch0_o,
  output logic timer_two_ch0_o
);
  // bus clock counts every cycle, else the slow tick
  always_comb
  begin
    wdog_tick_o = clk_sel_i ? 1'b1 : khz_tick_i;
    timer_one_ch0_o = cmp_one_link_i & cmp_one_out_i;
    timer_two_ch0_o = cmp_two_link_i & cmp_two_out_i;
  end
endmodule

// file: system_options.sv
// Purpose: AXI4-Lite register bank for system options and part id.
// Assumes: one write and one read in flight at most from the master.
// Notes:   write-once bits lock on the first low-byte write after reset.
`timescale 1ns/1ns
module system_options
  import options_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // sources routed by the options
  input wire logic khz_tick_i,
  input wire logic cmp_one_out_i,
  input wire logic cmp_two_out_i,
  // option effects
  output logic wdog_tick_o,
  output logic wdog_clk_sel_o,
  output logic wdog_timeout_long_o,
  output logic serial_pins_on_port_e_o,
  output logic two_wire_pins_on_port_b_o,
  output logic timer_one_ch0_o,
  output logic timer_two_ch0_o
);
  // elaboration check: the decoder compares eight address bits
  if (ADDR_W < 8)
  begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // whole state of the bank
  typedef struct packed {
    logic aw_have; // write address held
    logic [7:0] aw_addr;
    logic w_have; // write data held
    logic [7:0] w_byte; // only the low lane is ever stored
    logic w_lane0; // low byte strobe
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic clk_sel; // watchdog clock source
    logic clk_sel_lock; // options two already written once
    logic serial_loc;
    logic two_wire_loc;
    logic cmp_one_link;
    logic cmp_two_link;
    logic timeout_long; // watchdog period length
    logic timeout_lock; // options one already written once
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;
  logic wr_fire; // both halves of a write are held
  logic rd_take; // read address accepted this edge
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  // word decode shared by reads and writes
  function automatic reg_sel_t decode(input logic [7:0] addr);
    unique case (addr)
      OFF_OPTIONS_TWO: decode = SEL_OPT_TWO;
      OFF_PART_ID_HIGH: decode = SEL_ID_HIGH;
      OFF_PART_ID_LOW: decode = SEL_ID_LOW;
      OFF_OPTIONS_ONE: decode = SEL_OPT_ONE;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // handshakes: one write and one read may be pending
  assign s_axi_awready = !state_reg.aw_have && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_have && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign wr_fire = state_reg.aw_have && state_reg.w_have;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_sel = decode(state_reg.aw_addr);
  assign rd_sel = decode(s_axi_araddr[7:0]);

  // next-state logic for channels and registers
  always_comb
  begin
    state_next = state_reg;
    // capture write address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.w_have = 1'b1;
      state_next.w_byte = s_axi_wdata[7:0];
      state_next.w_lane0 = s_axi_wstrb[0];
    end
    // perform the write once both halves are held
    if (wr_fire)
    begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      unique case (wr_sel)
        SEL_OPT_TWO:
        begin
          if (state_reg.w_lane0)
          begin
            // anytime bits; reserved 6-4 simply not stored
            state_next.serial_loc = state_reg.w_byte[BIT_SERIAL_LOC];
            state_next.two_wire_loc =
              state_reg.w_byte[BIT_TWO_WIRE_LOC];
            state_next.cmp_one_link =
              state_reg.w_byte[BIT_CMP_ONE_LINK];
            state_next.cmp_two_link =
              state_reg.w_byte[BIT_CMP_TWO_LINK];
            // clock select takes the first write only
            if (!state_reg.clk_sel_lock)
              state_next.clk_sel = state_reg.w_byte[BIT_WDOG_CLK_SEL];
            state_next.clk_sel_lock = 1'b1;
          end
        end
        SEL_OPT_ONE:
        begin
          // timeout length is write-once too
          if (state_reg.w_lane0 && !state_reg.timeout_lock)
            state_next.timeout_long =
              state_reg.w_byte[BIT_WDOG_TIMEOUT];
          if (state_reg.w_lane0)
            state_next.timeout_lock = 1'b1;
        end
        // id registers: accepted, nothing changes
        SEL_ID_HIGH, SEL_ID_LOW:
          state_next.bresp = RESP_OKAY;
        default:
          state_next.bresp = RESP_SLVERR;
      endcase
    end
    // retire the write response
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;
    // retire the read response
    if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
    // read answers one cycle after the address is taken
    if (rd_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = 8'h00;
      unique case (rd_sel)
        SEL_OPT_TWO:
        begin
          state_next.rdata[BIT_WDOG_CLK_SEL] = state_reg.clk_sel;
          state_next.rdata[BIT_SERIAL_LOC] = state_reg.serial_loc;
          state_next.rdata[BIT_CMP_TWO_LINK] = state_reg.cmp_two_link;
          state_next.rdata[BIT_TWO_WIRE_LOC] = state_reg.two_wire_loc;
          state_next.rdata[BIT_CMP_ONE_LINK] = state_reg.cmp_one_link;
        end
        SEL_OPT_ONE:
          state_next.rdata[BIT_WDOG_TIMEOUT] = state_reg.timeout_long;
        SEL_ID_HIGH:
          // reserved upper nibble reads zero
          state_next.rdata = {4'h0, PART_NUMBER[11:8]};
        SEL_ID_LOW:
          state_next.rdata = PART_NUMBER[7:0];
        default:
          state_next.rresp = RESP_SLVERR;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= '0;
      state_reg.clk_sel <= RST_WDOG_CLK_SEL;
      state_reg.serial_loc <= RST_SERIAL_LOC;
      state_reg.two_wire_loc <= RST_TWO_WIRE_LOC;
      state_reg.cmp_one_link <= RST_CMP_ONE_LINK;
      state_reg.cmp_two_link <= RST_CMP_TWO_LINK;
      state_reg.timeout_long <= RST_WDOG_TIMEOUT;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // register outputs
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = {24'h000000, state_reg.rdata};
  assign s_axi_rresp = state_reg.rresp;
  assign wdog_clk_sel_o = state_reg.clk_sel;
  assign wdog_timeout_long_o = state_reg.timeout_long;
  assign serial_pins_on_port_e_o = state_reg.serial_loc;
  assign two_wire_pins_on_port_b_o = state_reg.two_wire_loc;

  // routing of watchdog clock and comparator links
  option_routing u_routing (
    .clk_sel_i(state_reg.clk_sel),
    .cmp_one_link_i(state_reg.cmp_one_link),
    .cmp_two_link_i(state_reg.cmp_two_link),
    .khz_tick_i(khz_tick_i),
    .cmp_one_out_i(cmp_one_out_i),
    .cmp_two_out_i(cmp_two_out_i),
    .wdog_tick_o(wdog_tick_o),
    .timer_one_ch0_o(timer_one_ch0_o),
    .timer_two_ch0_o(timer_two_ch0_o)
  );
  // helper: a write to options two is performed this cycle
  logic opt2_wr;
  assign opt2_wr = wr_fire && wr_sel == SEL_OPT_TWO && state_reg.w_lane0;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  wdog_source_a: assert property (
    wdog_tick_o == (wdog_clk_sel_o ? 1'b1 : khz_tick_i))
    else $error("watchdog tick does not follow clock select");
  once_hold_a: assert property (
    state_reg.clk_sel_lock |=> $stable(wdog_clk_sel_o))
    else $error("locked clock select changed");
  once_first_a: assert property (
    opt2_wr && !state_reg.clk_sel_lock
      |=> wdog_clk_sel_o == $past(state_reg.w_byte[BIT_WDOG_CLK_SEL]))
    else $error("first write to clock select lost");
  serial_loc_a: assert property (
    opt2_wr |=> serial_pins_on_port_e_o
      == $past(state_reg.w_byte[BIT_SERIAL_LOC]))
    else $error("serial pin location not updated");
  twowire_loc_a: assert property (
    opt2_wr |=> two_wire_pins_on_port_b_o
      == $past(state_reg.w_byte[BIT_TWO_WIRE_LOC]))
    else $error("two-wire pin location not updated");
  cmp_one_a: assert property (
    timer_one_ch0_o == (state_reg.cmp_one_link && cmp_one_out_i))
    else $error("comparator one link wrong");
  cmp_two_a: assert property (
    opt2_wr |=> timer_two_ch0_o
      == ($past(state_reg.w_byte[BIT_CMP_TWO_LINK]) && cmp_two_out_i))
    else $error("comparator two link wrong");
  id_high_a: assert property (
    rd_take && rd_sel == SEL_ID_HIGH
      |=> s_axi_rdata[7:0] == {4'h0, PART_NUMBER[11:8]})
    else $error("id high read wrong");
  id_low_a: assert property (
    rd_take && rd_sel == SEL_ID_LOW |=> s_axi_rdata[7:0] == PART_NUMBER[7:0]
      && s_axi_rresp == RESP_OKAY)
    else $error("id low read wrong");
  id_split_a: assert property (
    rd_take && rd_sel == SEL_ID_HIGH ##1 s_axi_rready
      ##1 rd_take && rd_sel == SEL_ID_LOW
      |=> {$past(s_axi_rdata[3:0], 2), s_axi_rdata[7:0]} == PART_NUMBER)
    else $error("part number halves do not match");
  timeout_hold_a: assert property (
    state_reg.timeout_lock |=> $stable(wdog_timeout_long_o))
    else $error("locked timeout length changed");
  reserved_a: assert property (
    rd_take && rd_sel == SEL_OPT_TWO |=> s_axi_rdata[6:4] == 3'h0)
    else $error("reserved option bits read non-zero");
  wr_resp_a: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  opt_write_c: cover property (opt2_wr ##1 s_axi_bvalid);
  relock_c: cover property (opt2_wr && state_reg.clk_sel_lock);
  id_read_c: cover property (rd_take && rd_sel == SEL_ID_LOW);
  bad_addr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

// file: test_system_options_and_part_id.sv
// Purpose: self-checking bench for the options and part id register bank.
// Assumes: bench acts as AXI4-Lite master, driving by NBA after rising edges.
// Notes:   seed 45; random option bytes and comparator levels among corners.
`timescale 1ns/1ns
module test_system_options_and_part_id
  import options_pkg::*;
  ();
  // clock, reset and bus master signals
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic khz, cmp1, cmp2;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  // slave answers and option effects
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic tick, clk_sel, tmo_long, ser_e, tw_b, t1, t2;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int seed;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] v;

  system_options #(.ADDR_W(8)) i_dut (
    .clk_sys_i(clk), .reset_n_i(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .khz_tick_i(khz), .cmp_one_out_i(cmp1), .cmp_two_out_i(cmp2),
    .wdog_tick_o(tick), .wdog_clk_sel_o(clk_sel),
    .wdog_timeout_long_o(tmo_long), .serial_pins_on_port_e_o(ser_e),
    .two_wire_pins_on_port_b_o(tw_b),
    .timer_one_ch0_o(t1), .timer_two_ch0_o(t2));

  // 20 MHz system clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  // single place where the run ends
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // compare a value (register word or pin level)
  task automatic chk_val(input string what, input logic [31:0] e,
                         input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // compare a bus response code
  task automatic chk_resp(input string what, input logic [1:0] e,
                          input logic [1:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // expected options-two word: only bits 7 and 3-0 ever read back
  function automatic logic [31:0] exp_opt(input logic sel,
                                          input logic [7:0] x);
    return {24'h00_0000, sel, 3'h0, x[3:0]};
  endfunction

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] x,
                    input logic [3:0] s, output logic [1:0] rs);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= {24'($urandom), x};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // read: hold the address until taken, rready until data seen
  task automatic rd(input logic [7:0] a, output logic [31:0] x,
                    output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    x = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // random sources for some cycles, routed pins checked each cycle
  task automatic pins(input logic sel, input logic [7:0] x);
    repeat (6)
    begin
      khz <= 1'($urandom);
      cmp1 <= 1'($urandom);
      cmp2 <= 1'($urandom);
      @(posedge clk);
      chk_val("clk sel", {31'h0, sel}, {31'h0, clk_sel});
      chk_val("wdog tick", {31'h0, sel | khz}, {31'h0, tick});
      chk_val("serial loc", {31'h0, x[3]}, {31'h0, ser_e});
      chk_val("two wire loc", {31'h0, x[1]}, {31'h0, tw_b});
      chk_val("timer one", {31'h0, x[0] & cmp1}, {31'h0, t1});
      chk_val("timer two", {31'h0, x[2] & cmp2}, {31'h0, t2});
    end
  endtask

  // main sequence
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {khz, cmp1, cmp2} = 3'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    seed = $urandom(45);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // reset state
    rd(OFF_OPTIONS_TWO, d, r);
    chk_val("opt two reset", exp_opt(RST_WDOG_CLK_SEL, 8'h00), d);
    rd(OFF_OPTIONS_ONE, d, r);
    chk_val("timeout reset", 32'(RST_WDOG_TIMEOUT), 32'(d[6]));
    pins(1'b0, 8'h00);
    $display("test reset done");
    // id registers: constant, writes ignored, number spans both
    for (int i = 0; i < 2; i++)
    begin
      wr(OFF_PART_ID_HIGH, 8'hFF, 4'hF, r);
      chk_resp("id high wr", RESP_OKAY, r);
      wr(OFF_PART_ID_LOW, 8'h00, 4'hF, r);
      rd(OFF_PART_ID_HIGH, d, r);
      chk_val("id high", 32'(PART_NUMBER[11:8]), 32'(d[3:0]));
      rd(OFF_PART_ID_LOW, d, r);
      chk_val("id low", 32'(PART_NUMBER[7:0]), d);
    end
    $display("test part id done");
    // unstrobed write neither changes nor locks the clock select
    wr(OFF_OPTIONS_TWO, 8'h8F, 4'hE, r);
    rd(OFF_OPTIONS_TWO, d, r);
    chk_val("no strobe", exp_opt(1'b0, 8'h00), d);
    // first strobed write locks select at 1, later bytes random
    wr(OFF_OPTIONS_TWO, 8'hF5, 4'h1, r);
    pins(1'b1, 8'hF5);
    repeat (10)
    begin
      v = 8'($urandom);
      wr(OFF_OPTIONS_TWO, v, 4'h1, r);
      rd(OFF_OPTIONS_TWO, d, r);
      chk_val("opt two", exp_opt(1'b1, v), d);
      chk_resp("opt two rd", RESP_OKAY, r);
      pins(1'b1, v);
    end
    $display("test options two done");
    // timeout length: first write sets short, second is ignored
    wr(OFF_OPTIONS_ONE, 8'h00, 4'h1, r);
    wr(OFF_OPTIONS_ONE, 8'h40, 4'h1, r);
    rd(OFF_OPTIONS_ONE, d, r);
    chk_val("timeout bit", 32'h0, 32'(d[6]));
    chk_val("timeout pin", 32'h0, 32'(tmo_long));
    $display("test timeout done");
    // unmapped places answer with an error and change nothing
    wr(8'h10, 8'h00, 4'h1, r);
    chk_resp("bad wr", RESP_SLVERR, r);
    rd(8'hFC, d, r);
    chk_resp("bad rd", RESP_SLVERR, r);
    chk_val("bad rd data", 32'h0, d);
    $display("test unmapped done");
    // second reset: select back to 0, locks at 0 on first write
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk_val("timeout rst", 32'(RST_WDOG_TIMEOUT), 32'(tmo_long));
    wr(OFF_OPTIONS_TWO, 8'h00, 4'h1, r);
    wr(OFF_OPTIONS_TWO, 8'h80, 4'h1, r);
    rd(OFF_OPTIONS_TWO, d, r);
    chk_val("relock", exp_opt(1'b0, 8'h00), d);
    pins(1'b0, 8'h00);
    $display("test second reset done");
    test_done();
  end
endmodule
